//--- dv/dbp_board.sv
// Board-side pad model: resolves each pad from the block drive, external drive and pull-up.
`timescale 1ns/1ps
module dbp_board #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in, // Core clock.
    input wire logic [WIDTH-1:0] drv_in, // Block drive values.
    input wire logic [WIDTH-1:0] oe_in, // Block drive enables.
    input wire logic [WIDTH-1:0] pullup_in, // Weak pull-up enables.
    input wire logic [WIDTH-1:0] ext_oe_in, // Board drives the pad.
    input wire logic [WIDTH-1:0] ext_val_in, // Board drive values.
    output logic [WIDTH-1:0] level_out // Resolved pad levels.
);
    logic [WIDTH-1:0] last = '0;

    // A floating pad toggles every cycle so a missing drive is never mistaken for a level.
    always_ff @(posedge clk_in) begin
        last <= level_out;
    end

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (oe_in[i]) begin
                level_out[i] = drv_in[i];
            end else if (ext_oe_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pullup_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = ~last[i];
            end
        end
    end
endmodule

//--- dv/tb_dbp_gpio_top.sv
// Self-checking testbench for the dual port block.
`timescale 1ns/1ps
`include "dbp_map.svh"
module tb_dbp_gpio_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic warm = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata, f_in, f_out, f_oe, f_pu, s_in, s_out, s_oe, s_sync, got;
    logic [7:0] ovr_en = 8'h00, ovr_dir = 8'h00, p_out = 8'h00;
    logic [7:0] f_xoe = 8'hFF, f_xv = 8'h00, s_xoe = 8'hFF, s_xv = 8'h00;
    logic pmode = 1'b0, pdoe = 1'b0, pd = 1'b0;
    logic pclk, pdat, chg;
    logic [3:0] ext, e;
    int failures = 0;
    int samples_checked = 0;

    always #25 clk = ~clk;

    dbp_gpio_top u_dbp_gpio_top (.core_clk_in(clk), .rstn_in(rstn), .warm_rst_in(warm),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
        .first_pins_in(f_in), .first_pins_out(f_out), .first_pins_oe_out(f_oe),
        .first_pullup_out(f_pu), .second_pins_in(s_in), .second_pins_out(s_out),
        .second_pins_oe_out(s_oe), .second_pins_sync_out(s_sync),
        .periph_ovr_en_in(ovr_en), .periph_ovr_dir_in(ovr_dir), .periph_out_in(p_out),
        .prog_mode_in(pmode), .prog_data_oe_in(pdoe), .prog_data_in(pd),
        .prog_clk_out(pclk), .prog_data_out(pdat), .change_req_out(chg), .ext_req_out(ext));
    dbp_board u_board_first (.clk_in(clk), .drv_in(f_out), .oe_in(f_oe), .pullup_in(f_pu),
        .ext_oe_in(f_xoe), .ext_val_in(f_xv), .level_out(f_in));
    dbp_board u_board_second (.clk_in(clk), .drv_in(s_out), .oe_in(s_oe), .pullup_in(8'h00),
        .ext_oe_in(s_xoe), .ext_val_in(s_xv), .level_out(s_in));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(`DBP_OFF_FIRST_DIR, 8'hFF);
        rd_chk(`DBP_OFF_SECOND_DIR, 8'hFF);
        rd_chk(`DBP_OFF_CTL_MAIN, 8'h00);
        rd_chk(`DBP_OFF_CTL_EDGE, 8'hFF);
        rd_chk(`DBP_OFF_CTL_EXT, 8'hC0);
        rd_chk(4'h9, 8'h00);
        chk(f_pu, 8'h00);
        chk(f_oe | s_oe, 8'h00);
        wr(`DBP_OFF_FIRST_LAT, 8'hA5);
        wr(`DBP_OFF_FIRST_DIR, 8'h0F);
        f_xv <= 8'h03;
        rd_chk(`DBP_OFF_FIRST_LAT, 8'hA5);
        settle(3);
        chk(f_oe, 8'hF0);
        chk(f_out & f_oe, 8'hA0);
        rd_chk(`DBP_OFF_FIRST_PINS, 8'hA3);
        wr(`DBP_OFF_FIRST_PINS, 8'h5A);
        rd_chk(`DBP_OFF_FIRST_LAT, 8'h5A);
        chk(f_out & f_oe, 8'h50);
        wr(`DBP_OFF_CTL_EDGE, 8'h7F);
        settle(2);
        chk(f_pu, 8'h0F);
        f_xoe <= 8'hF0;
        settle(4);
        rd_chk(`DBP_OFF_FIRST_PINS, 8'h5F);
        f_xoe <= 8'hFF;
        wr(`DBP_OFF_CTL_EDGE, 8'hFF);
        // The peripheral forces bits 1 and 3 out and bits 0 and 2 in.
        wr(`DBP_OFF_SECOND_LAT, 8'h3C);
        ovr_en <= 8'h0F;
        ovr_dir <= 8'h05;
        p_out <= 8'hFF;
        settle(2);
        chk(s_oe, 8'h0A);
        chk(s_out & s_oe, 8'h0A);
        rd_chk(`DBP_OFF_SECOND_DIR, 8'hFF);
        wr(`DBP_OFF_SECOND_DIR, 8'h00);
        settle(5);
        chk(s_oe, 8'hFA);
        chk(s_sync, 8'h3A);
        rd_chk(`DBP_OFF_SECOND_DIR, 8'h00);
        rd_chk(`DBP_OFF_SECOND_PINS, 8'h3A);
        @(posedge clk);
        ovr_en <= 8'h00;
        wr(`DBP_OFF_FIRST_DIR, 8'hFF);
        f_xv <= 8'h00;
        settle(4);
        rd(`DBP_OFF_FIRST_PINS, got);
        wr(`DBP_OFF_CTL_MAIN, 8'h08);
        settle(3);
        chk({7'h00, chg}, 8'h00);
        f_xv <= 8'h80;
        settle(5);
        chk({7'h00, chg}, 8'h01);
        wr(`DBP_OFF_CTL_MAIN, 8'h08);
        settle(3);
        chk({7'h00, chg}, 8'h01);
        rd(`DBP_OFF_FIRST_PINS, got);
        wr(`DBP_OFF_CTL_MAIN, 8'h08);
        settle(2);
        chk({7'h00, chg}, 8'h00);
        wr(`DBP_OFF_FIRST_DIR, 8'h7F);
        settle(5);
        chk({7'h00, chg}, 8'h00);
        wr(`DBP_OFF_FIRST_DIR, 8'hFF);
        settle(4);
        wr(`DBP_OFF_CTL_MAIN, 8'h10);
        wr(`DBP_OFF_CTL_EXT, 8'hF8);
        settle(2);
        e = 4'h0;
        chk({4'h0, ext}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            f_xv[i] <= 1'b1;
            e[i] = 1'b1;
            settle(5);
            chk({4'h0, ext}, {4'h0, e});
        end
        // External input zero switched to falling-edge detection.
        wr(`DBP_OFF_CTL_EDGE, 8'hBF);
        wr(`DBP_OFF_CTL_MAIN, 8'h10);
        settle(2);
        chk({4'h0, ext}, 8'h0E);
        f_xv[0] <= 1'b0;
        settle(5);
        chk({4'h0, ext}, 8'h0F);
        wr(`DBP_OFF_CTL_MAIN, 8'h00);
        wr(`DBP_OFF_FIRST_DIR, 8'h00);
        pmode <= 1'b1;
        pdoe <= 1'b1;
        pd <= 1'b1;
        f_xv <= 8'h40;
        settle(7);
        chk(f_oe, 8'hBF);
        chk({6'h00, pdat, pclk}, 8'h03);
        @(posedge clk);
        pmode <= 1'b0;
        @(posedge clk);
        warm <= 1'b1;
        @(posedge clk);
        warm <= 1'b0;
        rd_chk(`DBP_OFF_FIRST_DIR, 8'hFF);
        rd_chk(`DBP_OFF_FIRST_LAT, 8'h5A);
        rd_chk(`DBP_OFF_SECOND_LAT, 8'h3C);
        rd_chk(`DBP_OFF_CTL_EDGE, 8'hFF);
        stop_test();
    end
endmodule

//--- include/dbp_lane_if.sv
// Signals between the register core and one port lane.
`timescale 1ns/1ps
interface dbp_lane_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] ovr_en;
    logic [WIDTH-1:0] ovr_dir;
    logic [WIDTH-1:0] ovr_out;
    logic [WIDTH-1:0] eff_in;
    logic [WIDTH-1:0] pin_q;
    logic [WIDTH-1:0] oe_q;
    logic [WIDTH-1:0] sync;
    modport lane (input dir, latch, ovr_en, ovr_dir, ovr_out,
        output eff_in, pin_q, oe_q, sync);
    modport core (output dir, latch, ovr_en, ovr_dir, ovr_out,
        input eff_in, pin_q, oe_q, sync);
endinterface

//--- include/dbp_map.svh
// Register offsets, field positions and reset values of the dual port block.
`ifndef DBP_MAP_SVH
`define DBP_MAP_SVH
`define DBP_ADDR_W 4
`define DBP_OFF_FIRST_PINS 4'h0
`define DBP_OFF_FIRST_LAT 4'h1
`define DBP_OFF_FIRST_DIR 4'h2
`define DBP_OFF_CTL_MAIN 4'h3
`define DBP_OFF_CTL_EDGE 4'h4
`define DBP_OFF_CTL_EXT 4'h5
`define DBP_OFF_SECOND_PINS 4'h6
`define DBP_OFF_SECOND_LAT 4'h7
`define DBP_OFF_SECOND_DIR 4'h8
`define DBP_DIR_RST 8'hFF
`define DBP_CTL_MAIN_RST 8'h00
`define DBP_CTL_EDGE_RST 8'hFF
`define DBP_CTL_EXT_RST 8'hC0
`define DBP_B_CHG_FLAG 0
`define DBP_B_EXT0_FLAG 1
`define DBP_B_CHG_EN 3
`define DBP_B_EXT0_EN 4
`define DBP_B_PULLUP_N 7
`define DBP_B_EDGE0 6
`define DBP_B_EXT1_FLAG 0
`define DBP_B_EXT1_EN 3
`define DBP_B_PROG_CLK 6
`define DBP_B_PROG_DATA 7
`endif

//--- include/dbp_pkg.sv
// Shared types of the dual port block.
package dbp_pkg;
    typedef logic [7:0] dbp_byte_t;
    typedef logic [3:0] dbp_nib_t;
endpackage

//--- src/dbp_gpio_top.sv
// Dual eight-pin port block with pull-ups, pin interrupts and peripheral override.
//
// What this block does
// - A direction bit of one releases the pin driver; the pin is an input.
// - A direction bit of zero drives the pin from its output latch.
// - Reading an output latch register returns the latch, never the pins.
// - An enabled peripheral on the second port forces pin direction either way.
// - Peripheral overrides never enter the direction register.
// - Both direction registers reset to all ones on every reset.
// - Latches are undefined after power-on and kept by other resets.
// - First-port pins zero to three are external interrupt inputs zero to three.
// - First-port pins four to seven offer interrupt-on-change.
// - Every first-port pin has a weak pull-up under software control.
// - In programming mode first-port pins six and seven are clock and data.
// - Second-port pins are shared with timer, capture, serial and USART functions.
// - Each port is eight pins, each with its own direction bit.
// - Pull-ups turn on when the active-low control bit is cleared; off at reset.
// - A first-port pin configured as output has its pull-up off.
// - Upper input pins mismatching the last read value set the change flag.
// - Reading the first port ends the mismatch; a live mismatch keeps setting.
`timescale 1ns/1ps
`include "dbp_map.svh"
module dbp_gpio_top import dbp_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_in, // Core clock, 20 MHz.
    input wire logic rstn_in, // Power-on and brown-out reset, active low.
    input wire logic warm_rst_in, // Other reset sources, synchronous, one cycle or more.
    input wire logic [`DBP_ADDR_W-1:0] addr_in, // Register address.
    input wire logic [7:0] wdata_in, // Write data.
    input wire logic wr_in, // Write strobe.
    input wire logic rd_in, // Read strobe.
    output logic [7:0] rdata_out, // Read data, cycle after the strobe.
    input wire logic [WIDTH-1:0] first_pins_in, // First port pad levels.
    output logic [WIDTH-1:0] first_pins_out, // First port drive values.
    output logic [WIDTH-1:0] first_pins_oe_out, // First port drive enables.
    output logic [WIDTH-1:0] first_pullup_out, // First port weak pull-up enables.
    input wire logic [WIDTH-1:0] second_pins_in, // Second port pad levels.
    output logic [WIDTH-1:0] second_pins_out, // Second port drive values.
    output logic [WIDTH-1:0] second_pins_oe_out, // Second port drive enables.
    output logic [WIDTH-1:0] second_pins_sync_out, // Second port levels for peripherals.
    input wire logic [WIDTH-1:0] periph_ovr_en_in, // Peripheral owns the pin.
    input wire logic [WIDTH-1:0] periph_ovr_dir_in, // Forced direction, one is input.
    input wire logic [WIDTH-1:0] periph_out_in, // Peripheral drive values.
    input wire logic prog_mode_in, // Serial programming mode pin.
    input wire logic prog_data_oe_in, // Programmer logic drives the data pin.
    input wire logic prog_data_in, // Programmer logic data value.
    output logic prog_clk_out, // Programming clock seen on the pin.
    output logic prog_data_out, // Programming data seen on the pin.
    output logic change_req_out, // Port change flag and enable.
    output logic [3:0] ext_req_out // External pin flags and enables.
);
    dbp_byte_t first_dir;
    dbp_byte_t first_lat;
    dbp_byte_t second_dir;
    dbp_byte_t second_lat;
    dbp_byte_t ctl_main;
    dbp_byte_t ctl_edge;
    dbp_byte_t ctl_ext;
    dbp_nib_t last_read;
    dbp_nib_t ext_prev;
    dbp_nib_t ext_hit;
    dbp_nib_t ext_sel;
    dbp_byte_t next_rdata;
    logic prog_mode;
    logic mismatch;
    logic wr_main;
    logic wr_ext;
    logic first_pins_rd;
    logic first_pins_wr;

    dbp_lane_if #(.WIDTH(WIDTH)) first_if ();
    dbp_lane_if #(.WIDTH(WIDTH)) second_if ();

    initial begin
        if (WIDTH != 8) begin
            $error("dbp_gpio_top: ports are eight pins wide");
        end
    end

    dbp_sync #(.WIDTH(1)) u_prog_sync (
        .clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .d_in(prog_mode_in),
        .q_out(prog_mode)
    );

    dbp_port_lane #(.WIDTH(WIDTH)) u_first (
        .clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .pins_in(first_pins_in),
        .lane(first_if.lane)
    );

    dbp_port_lane #(.WIDTH(WIDTH)) u_second (
        .clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .pins_in(second_pins_in),
        .lane(second_if.lane)
    );

    assign wr_main = wr_in && (addr_in == `DBP_OFF_CTL_MAIN);
    assign wr_ext = wr_in && (addr_in == `DBP_OFF_CTL_EXT);
    assign first_pins_rd = rd_in && (addr_in == `DBP_OFF_FIRST_PINS);
    assign first_pins_wr = wr_in && (addr_in == `DBP_OFF_FIRST_PINS);

    // Programming mode takes the two upper pins: the clock is an input, data may turn.
    assign first_if.dir = first_dir;
    assign first_if.latch = first_lat;
    assign first_if.ovr_en = {prog_mode, prog_mode, 6'h00};
    assign first_if.ovr_dir = {~prog_data_oe_in, 1'b1, 6'h3F};
    assign first_if.ovr_out = {prog_data_in, 7'h00};
    assign second_if.dir = second_dir;
    assign second_if.latch = second_lat;
    assign second_if.ovr_en = periph_ovr_en_in;
    assign second_if.ovr_dir = periph_ovr_dir_in;
    assign second_if.ovr_out = periph_out_in;

    // Direction registers: ones on every reset, software writes only.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_dir <= `DBP_DIR_RST;
            second_dir <= `DBP_DIR_RST;
        end else if (warm_rst_in) begin
            first_dir <= `DBP_DIR_RST;
            second_dir <= `DBP_DIR_RST;
        end else if (wr_in) begin
            if (addr_in == `DBP_OFF_FIRST_DIR) begin
                first_dir <= wdata_in;
            end
            if (addr_in == `DBP_OFF_SECOND_DIR) begin
                second_dir <= wdata_in;
            end
        end
    end

    // Latches carry no reset: undefined after power-on and kept by warm resets.
    always_ff @(posedge core_clk_in) begin
        if (wr_in && !warm_rst_in) begin
            if (addr_in == `DBP_OFF_FIRST_PINS || addr_in == `DBP_OFF_FIRST_LAT) begin
                first_lat <= wdata_in;
            end
            if (addr_in == `DBP_OFF_SECOND_PINS || addr_in == `DBP_OFF_SECOND_LAT) begin
                second_lat <= wdata_in;
            end
        end
    end

    // Reference value for the change compare, taken at each port read or write.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_read <= 4'h0;
        end else if (first_pins_rd || first_pins_wr) begin
            last_read <= first_if.sync[7:4];
        end
    end

    assign mismatch = |((first_if.sync[7:4] ^ last_read) & first_if.eff_in[7:4]);

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_prev <= 4'h0;
        end else begin
            ext_prev <= first_if.sync[3:0];
        end
    end

    // Edge select bits sit in descending order, one means rising edge.
    assign ext_sel = ctl_edge[`DBP_B_EDGE0 -: 4];
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ext_hit[i] = ext_sel[3 - i] ? (first_if.sync[i] & ~ext_prev[i])
                                        : (~first_if.sync[i] & ext_prev[i]);
        end
    end

    // Hardware sets win over a software clear in the same cycle.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_main <= `DBP_CTL_MAIN_RST;
        end else if (warm_rst_in) begin
            ctl_main <= {7'h00, ctl_main[`DBP_B_CHG_FLAG]};
        end else begin
            if (wr_main) begin
                ctl_main <= wdata_in;
            end
            if (mismatch) begin
                ctl_main[`DBP_B_CHG_FLAG] <= 1'b1;
            end
            if (ext_hit[0]) begin
                ctl_main[`DBP_B_EXT0_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_ext <= `DBP_CTL_EXT_RST;
        end else if (warm_rst_in) begin
            ctl_ext <= `DBP_CTL_EXT_RST;
        end else begin
            if (wr_ext) begin
                ctl_ext <= wdata_in;
            end
            for (int i = 0; i < 3; i++) begin
                if (ext_hit[i + 1]) begin
                    ctl_ext[`DBP_B_EXT1_FLAG + i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_edge <= `DBP_CTL_EDGE_RST;
        end else if (warm_rst_in) begin
            ctl_edge <= `DBP_CTL_EDGE_RST;
        end else if (wr_in && addr_in == `DBP_OFF_CTL_EDGE) begin
            ctl_edge <= wdata_in;
        end
    end

    // Pull-ups follow the effective direction, so a programming-mode data drive also drops it.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_pullup_out <= '0;
        end else begin
            first_pullup_out <= ctl_edge[`DBP_B_PULLUP_N] ? '0 : first_if.eff_in;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        unique case (addr_in)
            `DBP_OFF_FIRST_PINS: next_rdata = first_if.sync;
            `DBP_OFF_FIRST_LAT: next_rdata = first_lat;
            `DBP_OFF_FIRST_DIR: next_rdata = first_dir;
            `DBP_OFF_CTL_MAIN: next_rdata = ctl_main;
            `DBP_OFF_CTL_EDGE: next_rdata = ctl_edge;
            `DBP_OFF_CTL_EXT: next_rdata = ctl_ext;
            `DBP_OFF_SECOND_PINS: next_rdata = second_if.sync;
            `DBP_OFF_SECOND_LAT: next_rdata = second_lat;
            `DBP_OFF_SECOND_DIR: next_rdata = second_dir;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= 8'h00;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            change_req_out <= 1'b0;
            ext_req_out <= 4'h0;
            prog_clk_out <= 1'b0;
            prog_data_out <= 1'b0;
            second_pins_sync_out <= '0;
        end else begin
            change_req_out <= ctl_main[`DBP_B_CHG_FLAG] & ctl_main[`DBP_B_CHG_EN];
            ext_req_out[0] <= ctl_main[`DBP_B_EXT0_FLAG] & ctl_main[`DBP_B_EXT0_EN];
            ext_req_out[3:1] <= ctl_ext[`DBP_B_EXT1_FLAG +: 3] & ctl_ext[`DBP_B_EXT1_EN +: 3];
            prog_clk_out <= prog_mode & first_if.sync[`DBP_B_PROG_CLK];
            prog_data_out <= prog_mode & first_if.sync[`DBP_B_PROG_DATA];
            second_pins_sync_out <= second_if.sync;
        end
    end

    assign first_pins_out = first_if.pin_q;
    assign first_pins_oe_out = first_if.oe_q;
    assign second_pins_out = second_if.pin_q;
    assign second_pins_oe_out = second_if.oe_q;

    dir_reset_ones_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        warm_rst_in |=> first_dir == 8'hFF && second_dir == 8'hFF ##1 first_pins_oe_out == 8'h00)
        else $error("direction not all inputs after reset");
    latch_read_back_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        rd_in && addr_in == `DBP_OFF_FIRST_LAT |=> rdata_out == $past(first_lat))
        else $error("latch read does not return latch");
    override_not_stored_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !(wr_in && addr_in == `DBP_OFF_SECOND_DIR) && !warm_rst_in |=> $stable(second_dir))
        else $error("direction register changed without a write");
    override_drives_pin_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        periph_ovr_en_in != 8'h00 |=> (second_pins_oe_out & $past(periph_ovr_en_in))
            == $past(periph_ovr_en_in & ~periph_ovr_dir_in))
        else $error("peripheral override does not force the pin direction");
    pullup_off_out_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        first_if.eff_in != 8'hFF |=> (first_pullup_out & ~$past(first_if.eff_in)) == 8'h00)
        else $error("pull-up active on an output pin");
    pullup_ctrl_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        ctl_edge[`DBP_B_PULLUP_N] |=> first_pullup_out == 8'h00)
        else $error("pull-ups on while disabled");
    change_flag_set_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        mismatch && !warm_rst_in |=> ctl_main[`DBP_B_CHG_FLAG])
        else $error("mismatch did not set change flag");
    read_ends_match_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        first_pins_rd |=> last_read == $past(first_if.sync[7:4]))
        else $error("port read did not capture compare value");
    ext_edge_flag_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        ext_hit[1] && !warm_rst_in |=> ctl_ext[`DBP_B_EXT1_FLAG])
        else $error("external edge did not set its flag");
    read_data_one_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data outside its cycle");
endmodule

//--- src/dbp_port_lane.sv
// One bidirectional port: direction with override, pin drive and input sampling.
`timescale 1ns/1ps
module dbp_port_lane #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in, // Core clock.
    input wire logic rstn_in, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] pins_in, // Pin levels from the pads.
    dbp_lane_if.lane lane // Core side.
);
    logic [WIDTH-1:0] value;

    initial begin
        if (WIDTH != 8) begin
            $error("dbp_port_lane: ports are eight pins wide");
        end
    end

    // An override acts only here; the direction register is never touched.
    assign lane.eff_in = (lane.ovr_en & lane.ovr_dir) | (~lane.ovr_en & lane.dir);
    assign value = (lane.ovr_en & lane.ovr_out) | (~lane.ovr_en & lane.latch);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lane.oe_q <= '0;
            lane.pin_q <= '0;
        end else begin
            lane.oe_q <= ~lane.eff_in;
            lane.pin_q <= ~lane.eff_in & value;
        end
    end

    dbp_sync #(.WIDTH(WIDTH)) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .d_in(pins_in),
        .q_out(lane.sync)
    );

    oe_follows_dir_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        lane.oe_q == ~$past(lane.eff_in))
        else $error("pin enable does not follow effective direction");
    drive_value_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $past(!lane.eff_in[0] && !lane.ovr_en[0]) |-> lane.pin_q[0] == $past(lane.latch[0]))
        else $error("output pin does not carry the latch");
endmodule

//--- src/dbp_sync.sv
// Two-stage synchroniser for pin levels.
`timescale 1ns/1ps
module dbp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in, // Core clock.
    input wire logic rstn_in, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] d_in, // Asynchronous level.
    output logic [WIDTH-1:0] q_out // Synchronised level.
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("dbp_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule
